/* File: rtl/psim_consts.vh */
// constants for the pedal and sustain input mapper
// assumes inclusion by rtl/psim_top.v and the testbench
`ifndef PSIM_CONSTS_VH
`define PSIM_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PSIM_OFF_CTRL     12'h000
`define PSIM_OFF_PEDAL    12'h004
`define PSIM_OFF_STATUS   12'h008
`define PSIM_OFF_HELD     12'h00C
`define PSIM_OFF_NOTES    12'h010

// ----------------------------------------
// control register fields
// ----------------------------------------
`define PSIM_CTRL_DEST_LSB  0
`define PSIM_CTRL_SUS_LSB   4
`define PSIM_CTRL_HOLD_BIT  8
`define PSIM_CTRL_RESET     32'h0000_0000

// ----------------------------------------
// pedal destinations
// ----------------------------------------
`define PSIM_DEST_FOOT    3'h0
`define PSIM_DEST_MODW    3'h1
`define PSIM_DEST_BREATH  3'h2
`define PSIM_DEST_VOLUME  3'h3
`define PSIM_DEST_EXPR    3'h4
`define PSIM_DEST_GLIDE   3'h5
`define PSIM_DEST_PRESS   3'h6

// ----------------------------------------
// switch input modes
// ----------------------------------------
`define PSIM_SUS_HOLD_CLOSE  4'h0
`define PSIM_SUS_HOLD_OPEN   4'h1
`define PSIM_SUS_TAP_CLOSE   4'h2
`define PSIM_SUS_TAP_OPEN    4'h3
`define PSIM_SUS_ARP_HIGH    4'h4
`define PSIM_SUS_ARP_LOW     4'h5
`define PSIM_SUS_SEQ_RISE    4'h6
`define PSIM_SUS_SEQ_FALL    4'h7
`define PSIM_SUS_BOTH_HIGH   4'h8
`define PSIM_SUS_BOTH_LOW    4'h9

// ----------------------------------------
// axi responses
// ----------------------------------------
`define PSIM_RESP_OKAY    2'h0
`define PSIM_RESP_SLVERR  2'h2

`endif

/* File: rtl/psim_top.v */
// pedal and sustain input mapper with an axi4-lite register slave
// assumes pedal_level is an adc code of the pedal voltage and
// switch_closed is an asynchronous contact level
//
// Operation
// - pedal value rises as pedal is pressed
// - pedal value goes to at most one destination, foot default
// - closing hold: closed contact holds notes
// - opening hold: open contact holds notes
// - tap modes send one tap per press
// - arp high gate: step, hold while high
// - arp low gate: step, hold while low
// - seq rising: advance on each rising edge
// - seq falling: advance on each falling edge
// - combined high: arp high plus rising advance
// - combined low: arp low plus falling advance
// - sustain: all notes held while pressed
// - sostenuto: only notes active at press held
`timescale 1ns/1ps
`include "psim_consts.vh"

module psim_top #(
	parameter ADC_W   = 12,
	parameter NOTES_N = 16
) (
	// clock and reset
	input  wire                aclk,
	input  wire                aresetn,
	// axi4-lite write address
	input  wire [11:0]         s_axi_awaddr,
	input  wire                s_axi_awvalid,
	output reg                 s_axi_awready,
	// axi4-lite write data
	input  wire [31:0]         s_axi_wdata,
	input  wire [3:0]          s_axi_wstrb,
	input  wire                s_axi_wvalid,
	output reg                 s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]          s_axi_bresp,
	output reg                 s_axi_bvalid,
	input  wire                s_axi_bready,
	// axi4-lite read address
	input  wire [11:0]         s_axi_araddr,
	input  wire                s_axi_arvalid,
	output reg                 s_axi_arready,
	// axi4-lite read data
	output reg  [31:0]         s_axi_rdata,
	output reg  [1:0]          s_axi_rresp,
	output reg                 s_axi_rvalid,
	input  wire                s_axi_rready,
	// rear panel inputs
	input  wire [ADC_W-1:0]    pedal_level,
	input  wire                switch_closed,
	// voice side
	input  wire [NOTES_N-1:0]  notes_active,
	// pedal destinations
	output reg  [ADC_W-1:0]    foot_ctrl_q,
	output reg  [ADC_W-1:0]    mod_wheel_q,
	output reg  [ADC_W-1:0]    breath_q,
	output reg  [ADC_W-1:0]    volume_q,
	output reg  [ADC_W-1:0]    expression_q,
	output reg  [ADC_W-1:0]    glide_time_q,
	output reg  [ADC_W-1:0]    pressure_q,
	// switch functions
	output reg  [NOTES_N-1:0]  notes_held_q,
	output reg                 tap_pulse_q,
	output reg                 arp_step_q,
	output reg                 arp_gate_q,
	output reg                 seq_step_q
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg  [2:0]          dest_q;
	reg  [3:0]          sus_mode_q;
	reg                 sosten_q;
	reg                 sync1_q;
	reg                 sync2_q;
	reg                 prev_q;
	reg  [NOTES_N-1:0]  latch_q;
	reg  [ADC_W-1:0]    pedal_q;
	reg  [7:0]          tap_cnt_q;
	reg  [7:0]          seq_cnt_q;
	reg  [7:0]          arp_cnt_q;
	reg  [11:0]         aw_q;
	reg                 aw_have_q;
	reg  [31:0]         wd_q;
	reg  [3:0]          ws_q;
	reg                 wd_have_q;

	// edges come from the second stage only, never the first
	wire rise = sync2_q & ~prev_q;
	wire fall = ~sync2_q & prev_q;

	// press level for each mode; open-contact variants invert
	function active_level;
		input [3:0] m;
		input       closed;
		begin
			case (m)
			`PSIM_SUS_HOLD_OPEN, `PSIM_SUS_TAP_OPEN,
			`PSIM_SUS_ARP_LOW, `PSIM_SUS_SEQ_FALL,
			`PSIM_SUS_BOTH_LOW:
				active_level = ~closed;
			default:
				active_level = closed;
			endcase
		end
	endfunction

	wire pressed = active_level(sus_mode_q, sync2_q);
	wire press_edge = active_level(sus_mode_q, 1'b1) ? rise : fall;
	wire is_hold = (sus_mode_q == `PSIM_SUS_HOLD_CLOSE) ||
		(sus_mode_q == `PSIM_SUS_HOLD_OPEN);
	wire is_tap = (sus_mode_q == `PSIM_SUS_TAP_CLOSE) ||
		(sus_mode_q == `PSIM_SUS_TAP_OPEN);
	wire is_arp = (sus_mode_q == `PSIM_SUS_ARP_HIGH) ||
		(sus_mode_q == `PSIM_SUS_ARP_LOW) ||
		(sus_mode_q == `PSIM_SUS_BOTH_HIGH) ||
		(sus_mode_q == `PSIM_SUS_BOTH_LOW);
	wire is_seq = (sus_mode_q == `PSIM_SUS_SEQ_RISE) ||
		(sus_mode_q == `PSIM_SUS_SEQ_FALL) ||
		(sus_mode_q == `PSIM_SUS_BOTH_HIGH) ||
		(sus_mode_q == `PSIM_SUS_BOTH_LOW);

	// ----------------------------------------
	// input sync and switch functions
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q      <= 1'b0;
			sync2_q      <= 1'b0;
			prev_q       <= 1'b0;
			latch_q      <= {NOTES_N{1'b0}};
			notes_held_q <= {NOTES_N{1'b0}};
			tap_pulse_q  <= 1'b0;
			arp_step_q   <= 1'b0;
			arp_gate_q   <= 1'b0;
			seq_step_q   <= 1'b0;
			tap_cnt_q    <= 8'h00;
			seq_cnt_q    <= 8'h00;
			arp_cnt_q    <= 8'h00;
		end else begin
			sync1_q <= switch_closed;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
			// sostenuto latches the set of notes sounding at the press
			if (press_edge)
				latch_q <= notes_active;
			if (is_hold && pressed) begin
				// latch lands a cycle late, so take the notes at the press
				if (sosten_q && press_edge)
					notes_held_q <= notes_active;
				else if (sosten_q)
					notes_held_q <= latch_q;
				else
					notes_held_q <= {NOTES_N{1'b1}};
			end else begin
				notes_held_q <= {NOTES_N{1'b0}};
			end
			tap_pulse_q <= is_tap & press_edge;
			arp_step_q  <= is_arp & press_edge;
			arp_gate_q  <= is_arp & pressed;
			seq_step_q  <= is_seq & press_edge;
			if (is_tap & press_edge)
				tap_cnt_q <= tap_cnt_q + 8'h01;
			if (is_seq & press_edge)
				seq_cnt_q <= seq_cnt_q + 8'h01;
			if (is_arp & press_edge)
				arp_cnt_q <= arp_cnt_q + 8'h01;
		end
	end

	// ----------------------------------------
	// pedal value routing
	// ----------------------------------------
	// unused destinations park at zero so they never fight another source
	always @(posedge aclk) begin
		if (!aresetn) begin
			pedal_q      <= {ADC_W{1'b0}};
			foot_ctrl_q  <= {ADC_W{1'b0}};
			mod_wheel_q  <= {ADC_W{1'b0}};
			breath_q     <= {ADC_W{1'b0}};
			volume_q     <= {ADC_W{1'b0}};
			expression_q <= {ADC_W{1'b0}};
			glide_time_q <= {ADC_W{1'b0}};
			pressure_q   <= {ADC_W{1'b0}};
		end else begin
			pedal_q      <= pedal_level;
			foot_ctrl_q  <= (dest_q == `PSIM_DEST_FOOT) ?
				pedal_q : {ADC_W{1'b0}};
			mod_wheel_q  <= (dest_q == `PSIM_DEST_MODW) ?
				pedal_q : {ADC_W{1'b0}};
			breath_q     <= (dest_q == `PSIM_DEST_BREATH) ?
				pedal_q : {ADC_W{1'b0}};
			volume_q     <= (dest_q == `PSIM_DEST_VOLUME) ?
				pedal_q : {ADC_W{1'b0}};
			expression_q <= (dest_q == `PSIM_DEST_EXPR) ?
				pedal_q : {ADC_W{1'b0}};
			glide_time_q <= (dest_q == `PSIM_DEST_GLIDE) ?
				pedal_q : {ADC_W{1'b0}};
			pressure_q   <= (dest_q == `PSIM_DEST_PRESS) ?
				pedal_q : {ADC_W{1'b0}};
		end
	end

	// ----------------------------------------
	// axi4-lite write side
	// ----------------------------------------
	// one write in flight; address and data may come in either order
	wire wr_go = aw_have_q & wd_have_q & ~s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_q          <= 12'h000;
			aw_have_q     <= 1'b0;
			wd_q          <= 32'h0000_0000;
			ws_q          <= 4'h0;
			wd_have_q     <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PSIM_RESP_OKAY;
			dest_q        <= `PSIM_DEST_FOOT;
			sus_mode_q    <= `PSIM_SUS_HOLD_CLOSE;
			sosten_q      <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~wd_have_q & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_q      <= s_axi_awaddr;
				aw_have_q <= 1'b1;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wd_q      <= s_axi_wdata;
				ws_q      <= s_axi_wstrb;
				wd_have_q <= 1'b1;
			end
			if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_go) begin
				aw_have_q    <= 1'b0;
				wd_have_q    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `PSIM_RESP_OKAY;
				if ({aw_q[11:2], 2'b00} == `PSIM_OFF_CTRL) begin
					if (ws_q[0]) begin
						dest_q     <= wd_q[`PSIM_CTRL_DEST_LSB +: 3];
						sus_mode_q <= wd_q[`PSIM_CTRL_SUS_LSB +: 4];
					end
					if (ws_q[1])
						sosten_q <= wd_q[`PSIM_CTRL_HOLD_BIT];
				end else begin
					s_axi_bresp <= `PSIM_RESP_SLVERR;
				end
			end
		end
	end

	// ----------------------------------------
	// axi4-lite read side
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `PSIM_RESP_OKAY;
		end else begin
			// unmapped offsets answer slverr with zero data
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_rvalid & s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `PSIM_RESP_OKAY;
				case ({s_axi_araddr[11:2], 2'b00})
				`PSIM_OFF_CTRL:
					s_axi_rdata <= {23'h000000, sosten_q, sus_mode_q,
						1'b0, dest_q};
				`PSIM_OFF_PEDAL:
					s_axi_rdata <= {{(32-ADC_W){1'b0}}, pedal_q};
				`PSIM_OFF_STATUS:
					s_axi_rdata <= {5'h00, sync2_q, pressed, arp_gate_q,
						arp_cnt_q, seq_cnt_q, tap_cnt_q};
				`PSIM_OFF_HELD:
					s_axi_rdata <= {{(32-NOTES_N){1'b0}}, notes_held_q};
				`PSIM_OFF_NOTES:
					s_axi_rdata <= {{(32-NOTES_N){1'b0}}, latch_q};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `PSIM_RESP_SLVERR;
				end
				endcase
			end
		end
	end

endmodule

/* File: verif/psim_sva.sv */
// assertions for the pedal and sustain input mapper
// assumes binding to psim_top, sees its ports only
`timescale 1ns/1ps
module psim_sva #(
	parameter ADC_W = 12
) (
	// clock and reset
	input wire logic             aclk,
	input wire logic             aresetn,
	// register bus
	input wire logic             s_axi_awready,
	input wire logic             s_axi_bvalid,
	input wire logic             s_axi_bready,
	input wire logic             s_axi_rvalid,
	input wire logic             s_axi_rready,
	input wire logic [31:0]      s_axi_rdata,
	// pedal path
	input wire logic [ADC_W-1:0] pedal_level,
	input wire logic [ADC_W-1:0] foot_ctrl_q,
	input wire logic [ADC_W-1:0] mod_wheel_q,
	input wire logic [ADC_W-1:0] breath_q,
	input wire logic [ADC_W-1:0] volume_q,
	input wire logic [ADC_W-1:0] expression_q,
	input wire logic [ADC_W-1:0] glide_time_q,
	input wire logic [ADC_W-1:0] pressure_q,
	// switch functions
	input wire logic             tap_pulse_q,
	input wire logic             arp_step_q,
	input wire logic             arp_gate_q,
	input wire logic             seq_step_q
);
	// --------------------------------
	// properties
	// --------------------------------
	wire [ADC_W-1:0] dst_or = foot_ctrl_q | mod_wheel_q | breath_q |
		volume_q | expression_q | glide_time_q | pressure_q;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	tap_width_a: assert property (tap_pulse_q |=> !tap_pulse_q)
		else $error("tap pulse wider than one cycle");
	seq_width_a: assert property ($rose(seq_step_q) |=> $fell(seq_step_q))
		else $error("sequencer pulse wider than one cycle");
	arp_width_a: assert property (arp_step_q |=> !arp_step_q)
		else $error("arp step wider than one cycle");
	arp_gate_a: assert property (arp_step_q |-> arp_gate_q)
		else $error("arp step without gate");
	one_dest_a: assert property ($onehot0({|foot_ctrl_q, |mod_wheel_q,
		|breath_q, |volume_q, |expression_q, |glide_time_q, |pressure_q}))
		else $error("pedal value on more than one destination");
	pedal_follow_a: assert property (dst_or != 0 |->
		dst_or == $past(pedal_level, 2))
		else $error("pedal value does not follow input");
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid)
		else $error("write response dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	awready_one_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready wider than one cycle");
	cover property (tap_pulse_q);
	cover property (seq_step_q && arp_step_q);
	cover property (s_axi_rvalid && !s_axi_rready);
endmodule

/* File: verif/psim_pedal_model.sv */
// foot pedal and gate source on the rear panel inputs
// assumes the bench calls its tasks from one process
`timescale 1ns/1ps
module psim_pedal_model #(
	parameter ADC_W = 12
) (
	input  wire logic             aclk,
	output logic [ADC_W-1:0]      pedal_level,
	output logic                  switch_closed
);
	initial begin
		pedal_level = '0;
		switch_closed = 1'b0;
	end
	// codes cannot leave the full-scale span of the input
	task automatic set_level(input logic [ADC_W-1:0] v);
		@(posedge aclk);
		pedal_level <= v;
	endtask
	// level held for cyc edges, gate edges at least a cycle apart
	task automatic hold_contact(input logic closed, input int cyc);
		@(posedge aclk);
		switch_closed <= closed;
		repeat (cyc - 1) @(posedge aclk);
	endtask
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the pedal and sustain input mapper
// assumes psim_top, psim_pedal_model and psim_sva are compiled
`timescale 1ns/1ps
`include "psim_consts.vh"
module testbench;
	localparam ADC_W = 12;
	logic aclk = 0, aresetn = 0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [ADC_W-1:0] pedal_level, foot_ctrl_q, mod_wheel_q, breath_q;
	wire [ADC_W-1:0] volume_q, expression_q, glide_time_q, pressure_q;
	wire switch_closed, tap_pulse_q, arp_step_q, arp_gate_q, seq_step_q;
	logic [15:0] notes_active = '0;
	wire [15:0] notes_held_q;
	wire [7*ADC_W-1:0] dst_all = {pressure_q, glide_time_q, expression_q,
		volume_q, breath_q, mod_wheel_q, foot_ctrl_q};
	int fail_count = 0, total_checks = 0, n_tap = 0, n_arp = 0, n_seq = 0;
	int m, d, b_tap, b_arp, b_seq;
	logic [31:0] rd;
	logic [1:0] rsp;
	logic [11:0] lv;
	always #50 aclk = ~aclk;
	always @(posedge aclk) begin
		n_tap <= n_tap + (tap_pulse_q === 1'b1);
		n_arp <= n_arp + (arp_step_q === 1'b1);
		n_seq <= n_seq + (seq_step_q === 1'b1);
	end
	psim_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pedal_level,
		.switch_closed, .notes_active, .foot_ctrl_q, .mod_wheel_q,
		.breath_q, .volume_q, .expression_q, .glide_time_q, .pressure_q,
		.notes_held_q, .tap_pulse_q, .arp_step_q, .arp_gate_q, .seq_step_q);
	psim_pedal_model src_u (.aclk, .pedal_level, .switch_closed);
	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task chk(input string nm, input logic [95:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task rdreg(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task report_and_stop;
		$display("checks %0d failures %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		report_and_stop;
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		rdreg(`PSIM_OFF_CTRL);
		chk("ctrl reset", rd, `PSIM_CTRL_RESET);
		for (d = 0; d < 8; d++) begin
			lv = 12'h1A5 + 12'h200 * d[2:0];
			wr(`PSIM_OFF_CTRL, d);
			src_u.set_level(lv);
			repeat (4) @(posedge aclk);
			chk("route", dst_all, d < 7 ? {72'h0, lv} << (12 * d) : 0);
		end
		rdreg(`PSIM_OFF_PEDAL);
		chk("pedal reg", rd, 32'h0000_0FA5);
		rdreg(12'h020);
		chk("unmapped resp", rsp, `PSIM_RESP_SLVERR);
		chk("unmapped data", rd, 0);
		wr(`PSIM_OFF_PEDAL, 32'h1);
		chk("ro write resp", rsp, `PSIM_RESP_SLVERR);
		notes_active <= 16'h00F3;
		for (m = 0; m < 10; m++) begin
			wr(`PSIM_OFF_CTRL, m << 4);
			repeat (4) @(posedge aclk);
			b_tap = n_tap;
			b_arp = n_arp;
			b_seq = n_seq;
			src_u.hold_contact(1, 6);
			chk("gate closed", arp_gate_q, m == 4 || m == 8);
			chk("held closed", notes_held_q, m == 0 ? 16'hFFFF : 0);
			src_u.hold_contact(0, 6);
			chk("gate open", arp_gate_q, m == 5 || m == 9);
			chk("held open", notes_held_q, m == 1 ? 16'hFFFF : 0);
			src_u.hold_contact(1, 1);
			src_u.hold_contact(0, 6);
			chk("taps", n_tap - b_tap, (m == 2 || m == 3) * 2);
			chk("arp", n_arp - b_arp, (m == 4 || m == 5 || m > 7) * 2);
			chk("seq", n_seq - b_seq, (m > 5) * 2);
		end
		notes_active <= 16'h0003;
		wr(`PSIM_OFF_CTRL, 32'h100);
		src_u.hold_contact(1, 6);
		notes_active <= 16'h0033;
		repeat (4) @(posedge aclk);
		chk("sostenuto", notes_held_q, 16'h0003);
		rdreg(`PSIM_OFF_HELD);
		chk("held reg", rd, 32'h0000_0003);
		rdreg(`PSIM_OFF_NOTES);
		chk("latch reg", rd, 32'h0000_0003);
		rdreg(`PSIM_OFF_STATUS);
		chk("status reg", rd, 32'h0608_0804);
		src_u.hold_contact(0, 6);
		chk("sostenuto off", notes_held_q, 0);
		report_and_stop;
	end
endmodule
bind psim_top psim_sva #(.ADC_W(ADC_W)) sva_u (.aclk, .aresetn,
	.s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .pedal_level, .foot_ctrl_q,
	.mod_wheel_q, .breath_q, .volume_q, .expression_q, .glide_time_q,
	.pressure_q, .tap_pulse_q, .arp_step_q, .arp_gate_q, .seq_step_q);
